// ===== hdl/axil_regs.sv
`default_nettype none
`include "dec_erase_params.svh"
module axil_regs
  import dec_erase_pkg::*;
(
  // clocking
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // register side
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  status_in,
  input  wire logic        busy_in,
  output logic [7:0]       erase_addr_r,
  output logic [7:0]       flash_top_r
);

  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic       w_lane0_r;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `REG_ACC) || (a == `REG_STATUS) ||
             (a == `REG_ERASE_ADDR) || (a == `REG_EXT_CONFIG) ||
             (a == `REG_FLASH_TOP);
  endfunction : mapped

  // write channel capture, either order
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      awready   <= 1'b1;
      wready    <= 1'b1;
    end
    else if (clk_en)
    begin
      if (awvalid && awready)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready   <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_held_r  <= 1'b1;
        w_data_r  <= wdata[7:0];
        wready    <= 1'b0;
        w_lane0_r <= wstrb[0];
      end
      if (aw_held_r && w_held_r)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (bvalid && bready)
      begin
        // ready flags are flops, reopened once the response is taken
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // writable registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      erase_addr_r <= `ERASE_ADDR_RST;
      flash_top_r  <= `FLASH_TOP_RST;
    end
    else if (clk_en && aw_held_r && w_held_r && w_lane0_r)
    begin
      if (aw_addr_r == `REG_ERASE_ADDR)
        erase_addr_r <= w_data_r;
      if (aw_addr_r == `REG_FLASH_TOP)
        flash_top_r <= w_data_r;
    end
  end

  // read channel
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp  <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (araddr)
          `REG_ACC:        rdata <= {24'h000000, acc_in};
          `REG_STATUS:     rdata <= {24'h000000, status_in};
          `REG_ERASE_ADDR: rdata <= {24'h000000, erase_addr_r};
          `REG_EXT_CONFIG: rdata <= {31'h00000000, busy_in};
          `REG_FLASH_TOP:  rdata <= {24'h000000, flash_top_r};
          default:         rdata <= 32'h0000_0000;
        endcase
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : axil_regs
`default_nettype wire

// ===== hdl/dec_erase_exec.sv
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
`include "dec_erase_params.svh"
module dec_erase_exec
  import dec_erase_pkg::*;
(
  // clocking
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // instruction stream
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  file_register_operand,
  // results to the core
  output mem_wr_s          mem_wr_r,
  output logic             annul_r,
  output logic             retire_r,
  output logic             fetch_from_flash_ok_r,
  // flash controller
  output erase_req_s       erase_req_r,
  input  wire logic        erase_done,
  // axi4-lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  logic [7:0]  acc_r;
  logic [7:0]  status_r;
  logic        flash_busy_flag;
  logic [7:0]  erase_addr_r;
  logic [7:0]  flash_top_r;
  logic        annul_pend_r;
  exec_state_e state_r;
  exec_state_e state_nxt;

  logic [6:0]  opc;
  logic [7:0]  dec_val;
  logic        is_mem_dst;
  logic        is_acc_dst;
  logic        is_snz;
  logic        is_sz;
  logic        is_plain;
  logic        is_erase;
  logic        skip_take;
  logic        go;

  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - 8'h01;
  endfunction : dec8

  axil_regs u_regs (
    .clk          (clk),
    .reset        (reset),
    .clk_en       (clk_en),
    .awaddr       (awaddr),
    .awvalid      (awvalid),
    .awready      (awready),
    .wdata        (wdata),
    .wstrb        (wstrb),
    .wvalid       (wvalid),
    .wready       (wready),
    .bresp        (bresp),
    .bvalid       (bvalid),
    .bready       (bready),
    .araddr       (araddr),
    .arvalid      (arvalid),
    .arready      (arready),
    .rdata        (rdata),
    .rresp        (rresp),
    .rvalid       (rvalid),
    .rready       (rready),
    .acc_in       (acc_r),
    .status_in    (status_r),
    .busy_in      (flash_busy_flag),
    .erase_addr_r (erase_addr_r),
    .flash_top_r  (flash_top_r)
  );

  // opcode decode
  always_comb
  begin
    opc        = instr[`OPC_MSB:`OPC_LSB];
    dec_val    = dec8(file_register_operand);
    go         = clk_en && instr_valid && !annul_pend_r;
    is_mem_dst = (opc == `OPC_DEC_MEM) || (opc == `OPC_DECSNZ_MEM) ||
                 (opc == `OPC_DECSZ_MEM);
    is_acc_dst = (opc == `OPC_DEC_ACC) || (opc == `OPC_DECSNZ_ACC) ||
                 (opc == `OPC_DECSZ_ACC);
    is_snz     = (opc == `OPC_DECSNZ_MEM) || (opc == `OPC_DECSNZ_ACC);
    is_sz      = (opc == `OPC_DECSZ_MEM) || (opc == `OPC_DECSZ_ACC);
    is_plain   = (opc == `OPC_DEC_MEM) || (opc == `OPC_DEC_ACC);
    is_erase   = (instr == `OPC_ERASE);
    skip_take  = (is_snz && (dec_val != 8'h00)) ||
                 (is_sz && (dec_val == 8'h00));
  end

  // sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_EXEC, ST_ANNUL, ST_ERASE:
      begin
        if (!go)
          state_nxt = annul_pend_r && clk_en && instr_valid ? ST_ANNUL
                                                            : ST_IDLE;
        else if (is_erase)
          state_nxt = ST_ERASE;
        else
          state_nxt = ST_EXEC;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= ST_IDLE;
    else if (clk_en)
      state_r <= state_nxt;
  end

  // skip: annul the already-fetched successor
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      annul_pend_r <= 1'b0;
      annul_r      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (annul_pend_r && instr_valid)
      begin
        annul_pend_r <= 1'b0;
        annul_r      <= 1'b1;
      end
      else
      begin
        annul_r <= 1'b0;
        if (go && skip_take)
          annul_pend_r <= 1'b1;
      end
    end
  end

  // data-memory write back
  always_ff @(posedge clk)
  begin
    if (reset)
      mem_wr_r <= '0;
    else if (clk_en)
    begin
      mem_wr_r.we   <= go && is_mem_dst;
      mem_wr_r.addr <= instr[`ADDR_MSB:0];
      mem_wr_r.data <= dec_val;
    end
  end

  // accumulator and zero flag
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc_r    <= `ACC_RST;
      status_r <= `STATUS_RST;
    end
    else if (go)
    begin
      if (is_acc_dst)
        acc_r <= dec_val;
      if (is_plain)
        status_r[`ZERO_BIT] <= (dec_val == 8'h00);
    end
  end

  // retire pulse, one per executed instruction
  always_ff @(posedge clk)
  begin
    if (reset)
      retire_r <= 1'b0;
    else if (clk_en)
      retire_r <= go && (is_mem_dst || is_acc_dst || is_erase);
  end

  // erase request and busy flag
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      erase_req_r     <= '0;
      flash_busy_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      erase_req_r.start <= 1'b0;
      if (go && is_erase && !flash_busy_flag)
      begin
        erase_req_r.block <= erase_addr_r;
        if (erase_addr_r <= flash_top_r)
        begin
          erase_req_r.start <= 1'b1;
          flash_busy_flag   <= 1'b1;
        end
      end
      else if (erase_done)
        flash_busy_flag <= 1'b0;
    end
  end

  // flash fetch gate
  always_ff @(posedge clk)
  begin
    if (reset)
      fetch_from_flash_ok_r <= 1'b1;
    else if (clk_en)
      fetch_from_flash_ok_r <= !(flash_busy_flag && !erase_done) &&
                               !(go && is_erase);
  end

  chk_skip_annuls: assert property (@(posedge clk) disable iff (reset)
    (clk_en && go && skip_take) ##1 (clk_en && instr_valid) |=> annul_r)
    else $error("taken skip did not annul next instruction");

  chk_no_skip: assert property (@(posedge clk) disable iff (reset)
    (clk_en && go && (is_snz || is_sz) && !skip_take) |=> !annul_pend_r)
    else $error("untaken skip armed an annul");

  chk_mem_write: assert property (@(posedge clk) disable iff (reset)
    (go && is_mem_dst) |=>
      (mem_wr_r.we && mem_wr_r.data == $past(file_register_operand) - 8'h01))
    else $error("in-place decrement write wrong");

  chk_wrap_ff: assert property (@(posedge clk) disable iff (reset)
    (go && is_mem_dst && file_register_operand == 8'h00) |=>
      mem_wr_r.data == 8'hFF)
    else $error("decrement of zero did not wrap");

  chk_acc_load: assert property (@(posedge clk) disable iff (reset)
    (go && is_acc_dst) |=> (acc_r == $past(dec_val) && !mem_wr_r.we))
    else $error("accumulator decrement wrong");

  chk_zero_flag: assert property (@(posedge clk) disable iff (reset)
    (go && is_plain) |=> status_r[`ZERO_BIT] == ($past(dec_val) == 8'h00))
    else $error("zero flag wrong");

  chk_flags_kept: assert property (@(posedge clk) disable iff (reset)
    (go && (is_snz || is_sz)) |=> $stable(status_r))
    else $error("skip variant changed status");

  sequence erase_issue;
    clk_en && go && is_erase && !flash_busy_flag &&
      erase_addr_r <= flash_top_r;
  endsequence

  chk_busy_set: assert property (@(posedge clk) disable iff (reset)
    erase_issue |=> (flash_busy_flag && erase_req_r.start))
    else $error("erase did not set busy");

  chk_no_oob: assert property (@(posedge clk) disable iff (reset)
    (clk_en && go && is_erase && erase_addr_r > flash_top_r) |=>
      !erase_req_r.start)
    else $error("out-of-range erase started");

  chk_busy_clear: assert property (@(posedge clk) disable iff (reset)
    (clk_en && flash_busy_flag && erase_done && !(go && is_erase)) |=>
      !flash_busy_flag)
    else $error("busy not cleared on done");

  // multi-step skip: decrement arms, successor offered, successor dropped
  sequence skip_armed;
    clk_en && go && skip_take;
  endsequence

  sequence successor_offered;
    clk_en && instr_valid;
  endsequence

  chk_skip_quiet: assert property (@(posedge clk) disable iff (reset)
    skip_armed ##1 successor_offered |=> (!mem_wr_r.we && !retire_r))
    else $error("annulled instruction had an effect");

  chk_annul_state: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_ANNUL) |-> annul_r)
    else $error("annul state without annul pulse");

  chk_erase_retire: assert property (@(posedge clk) disable iff (reset)
    (state_r == ST_ERASE) |-> retire_r)
    else $error("erase did not retire in one cycle");

  chk_fetch_held: assert property (@(posedge clk) disable iff (reset)
    flash_busy_flag |-> !fetch_from_flash_ok_r)
    else $error("flash fetch allowed while busy");

  chk_plain_commit: assert property (@(posedge clk) disable iff (reset)
    (go && is_plain && is_mem_dst) |=>
      (mem_wr_r.we && retire_r &&
       status_r[`ZERO_BIT] == (mem_wr_r.data == 8'h00)))
    else $error("plain decrement not committed in one cycle");

  chk_wrap_acc: assert property (@(posedge clk) disable iff (reset)
    (go && is_acc_dst && file_register_operand == 8'h00) |=>
      acc_r == 8'hFF)
    else $error("accumulator decrement of zero did not wrap");

  chk_state_onehot: assert property (@(posedge clk) disable iff (reset)
    $onehot(state_r))
    else $error("sequencer state not one-hot");

endmodule : dec_erase_exec
`default_nettype wire

// ===== inc/dec_erase_params.svh
`ifndef DEC_ERASE_PARAMS_SVH
`define DEC_ERASE_PARAMS_SVH

// opcode match patterns (upper seven bits of the instruction word; erase matches the whole 16-bit word)
`define OPC_DEC_MEM      7'h07
`define OPC_DEC_ACC      7'h06
`define OPC_DECSNZ_MEM   7'h27
`define OPC_DECSNZ_ACC   7'h26
`define OPC_DECSZ_MEM    7'h17
`define OPC_DECSZ_ACC    7'h16
`define OPC_ERASE        16'h0003
`define OPC_MSB          15
`define OPC_LSB          9
`define ADDR_MSB         8
// register offsets over AXI4-Lite
`define REG_ACC          8'h00
`define REG_STATUS       8'h04
`define REG_ERASE_ADDR   8'h08
`define REG_EXT_CONFIG   8'h0C
`define REG_FLASH_TOP    8'h10
// field positions
`define ZERO_BIT         2
`define BUSY_BIT         0
// reset values
`define ACC_RST          8'h00
`define STATUS_RST       8'h00
`define FLASH_TOP_RST    8'hFF
`define ERASE_ADDR_RST   8'h00
// axi response codes
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ===== inc/dec_erase_pkg.sv
`default_nettype none
package dec_erase_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_ANNUL = 4'b0100,
    ST_ERASE = 4'b1000
  } exec_state_e;

  // request to the flash controller
  typedef struct packed {
    logic       start;
    logic [7:0] block;
  } erase_req_s;

  // write back to the data-memory register file
  typedef struct packed {
    logic       we;
    logic [8:0] addr;
    logic [7:0] data;
  } mem_wr_s;

endpackage : dec_erase_pkg
`default_nettype wire

// ===== testbench/decrement_and_flash_erase_exec_tb.sv
`default_nettype none
`include "dec_erase_params.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, a, b); end end
module decrement_and_flash_erase_exec_tb
  import dec_erase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, instr_valid = 1'b0, erase_done;
  logic [15:0] instr = 16'h0000;
  logic [7:0]  file_register_operand = 8'h00, awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00, last_block, acc_m = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, rs, bs;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic annul_r, retire_r, fetch_from_flash_ok_r, misuse, ret1, ann2;
  logic z_m = 1'b0, clk_en = 1'b1;
  mem_wr_s    mem_wr_r, wr1, wr2;
  erase_req_s erase_req_r, er1;
  int errors = 0, checked = 0, cycles = 0, erase_count, n;

  always #10 clk = ~clk;

  dec_erase_exec dut_u (.clk(clk), .reset(reset), .clk_en(clk_en),
    .instr(instr), .instr_valid(instr_valid),
    .file_register_operand(file_register_operand), .mem_wr_r(mem_wr_r),
    .annul_r(annul_r), .retire_r(retire_r),
    .fetch_from_flash_ok_r(fetch_from_flash_ok_r),
    .erase_req_r(erase_req_r), .erase_done(erase_done),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  flash_model #(.ERASE_CYCLES(40)) flash_u (.clk(clk), .reset(reset),
    .erase_req(erase_req_r), .erase_done(erase_done),
    .erase_count(erase_count), .last_block(last_block), .misuse(misuse));

  task test_done;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      test_done();
    end
  end

  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] v,
              output logic [1:0] r);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // offer one instruction, then a non-skipping skip-if-zero behind it
  // (leaves the zero flag alone, so the first one's flag stays visible)
  task run(input logic [15:0] ins, input logic [7:0] opnd);
    @(posedge clk);
    instr <= ins; file_register_operand <= opnd; instr_valid <= 1'b1;
    @(posedge clk);
    instr <= {`OPC_DECSZ_MEM, 9'h1AA}; file_register_operand <= 8'h10;
    #1 wr1 = mem_wr_r; ret1 = retire_r; er1 = erase_req_r;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 wr2 = mem_wr_r; ann2 = annul_r;
  endtask : run

  // kind: 0 plain, 1 skip if nonzero, 2 skip if zero
  task dec_case(input logic [6:0] op, input logic [7:0] opnd, input int k);
    logic [7:0] res;
    logic       skip;
    res = opnd - 8'h01;
    skip = (k == 1) ? (res != 8'h00) : (k == 2) ? (res == 8'h00) : 1'b0;
    if (!op[0]) acc_m = res;
    if (k == 0) z_m = (res == 8'h00);
    run({op, 9'h055}, opnd);
    `CHK(wr1.we, op[0])
    if (op[0]) `CHK({wr1.addr, wr1.data}, {9'h055, res})
    `CHK(ret1, 1'b1)
    `CHK(ann2, skip)
    `CHK(wr2.we, ~skip)
    axi_rd(`REG_ACC, d, rs);
    `CHK(d[7:0], acc_m)
    axi_rd(`REG_STATUS, d, rs);
    `CHK(d[`ZERO_BIT], z_m)
  endtask : dec_case

  task erase_wait;
    n = 0;
    while (fetch_from_flash_ok_r !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
  endtask : erase_wait

  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    `CHK(fetch_from_flash_ok_r, 1'b1)
    dec_case(`OPC_DEC_MEM, 8'h01, 0);
    dec_case(`OPC_DEC_MEM, 8'h00, 0);
    dec_case(`OPC_DEC_ACC, 8'h00, 0);
    dec_case(`OPC_DEC_ACC, 8'h01, 0);
    dec_case(`OPC_DECSNZ_MEM, 8'h05, 1);
    dec_case(`OPC_DECSNZ_ACC, 8'h01, 1);
    dec_case(`OPC_DECSZ_MEM, 8'h03, 2);
    dec_case(`OPC_DEC_MEM, 8'h5A, 0);
    dec_case(`OPC_DECSNZ_MEM, 8'h01, 1);
    dec_case(`OPC_DECSNZ_ACC, 8'h09, 1);
    dec_case(`OPC_DECSZ_MEM, 8'h01, 2);
    dec_case(`OPC_DECSZ_ACC, 8'h01, 2);
    dec_case(`OPC_DECSZ_ACC, 8'h00, 2);
    // frozen clock enable: an offered decrement must not execute
    @(posedge clk);
    clk_en <= 1'b0; instr <= {`OPC_DEC_ACC, 9'h055}; instr_valid <= 1'b1;
    file_register_operand <= 8'h33;
    repeat (2) @(posedge clk);
    clk_en <= 1'b1; instr_valid <= 1'b0;
    #1 `CHK(retire_r, 1'b0)
    axi_rd(`REG_ACC, d, rs);
    `CHK(d[7:0], acc_m)
    axi_rd(`REG_FLASH_TOP, d, rs);
    `CHK(d, 32'h000000FF)
    wstrb <= 4'hE;
    axi_wr(`REG_ERASE_ADDR, 32'h00000011);
    wstrb <= 4'hF;
    axi_rd(`REG_ERASE_ADDR, d, rs);
    `CHK({bs, d}, {`RESP_OKAY, 32'h00000000})
    axi_wr(`REG_ERASE_ADDR, 32'h00000083);
    run(`OPC_ERASE, 8'h00);
    `CHK({er1.start, er1.block, ret1}, {1'b1, 8'h83, 1'b1})
    `CHK(wr2.we, 1'b1)
    `CHK(fetch_from_flash_ok_r, 1'b0)
    axi_rd(`REG_EXT_CONFIG, d, rs);
    `CHK(d[`BUSY_BIT], 1'b1)
    erase_wait();
    axi_rd(`REG_EXT_CONFIG, d, rs);
    `CHK(d[`BUSY_BIT], 1'b0)
    `CHK({erase_count, last_block}, {32'd1, 8'h83})
    axi_wr(`REG_FLASH_TOP, 32'h00000040);
    axi_wr(`REG_ERASE_ADDR, 32'h00000041);
    run(`OPC_ERASE, 8'h00);
    `CHK(er1.start, 1'b0)
    axi_rd(`REG_EXT_CONFIG, d, rs);
    `CHK(d[`BUSY_BIT], 1'b0)
    axi_wr(`REG_ERASE_ADDR, 32'h00000040);
    run(`OPC_ERASE, 8'h00);
    `CHK({er1.start, er1.block}, {1'b1, 8'h40})
    erase_wait();
    `CHK(fetch_from_flash_ok_r, 1'b1)
    `CHK({erase_count, misuse}, {32'd2, 1'b0})
    axi_wr(8'h24, 32'h0000005A);
    `CHK(bs, `RESP_SLVERR)
    axi_rd(8'h20, d, rs);
    `CHK({rs, d}, {`RESP_SLVERR, 32'h0})
    test_done();
  end
endmodule : decrement_and_flash_erase_exec_tb
`default_nettype wire

// ===== testbench/flash_model.sv
`default_nettype none
module flash_model
  import dec_erase_pkg::*;
#(
  parameter int ERASE_CYCLES = 40
)
(
  // clocking
  input  wire logic       clk,
  input  wire logic       reset,
  // erase handshake
  input  wire erase_req_s erase_req,
  output logic            erase_done,
  // observation
  output int              erase_count,
  output logic [7:0]      last_block,
  output logic            misuse
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  always @(posedge clk)
  begin
    if (reset)
    begin
      erase_done  <= 1'b0;
      erase_count <= 0;
      last_block  <= 8'h00;
      misuse      <= 1'b0;
      cnt         <= 0;
    end
    else
    begin
      erase_done <= 1'b0;
      if (erase_req.start)
      begin
        // a new erase while one runs is a caller fault
        if (cnt != 0)
          misuse <= 1'b1;
        cnt         <= ERASE_CYCLES;
        erase_count <= erase_count + 1;
        last_block  <= erase_req.block;
      end
      else if (cnt == 1)
      begin
        erase_done <= 1'b1;
        cnt        <= 0;
      end
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule : flash_model
`default_nettype wire
